/* File: logic/pfil_defs.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the pwm fault input logic package users
`ifndef PFIL_DEFS_SVH
`define PFIL_DEFS_SVH

`define PFIL_OFS_CTRL 6'h00
`define PFIL_OFS_CMD 6'h04
`define PFIL_OFS_EVA 6'h08
`define PFIL_OFS_EVB 6'h0c
`define PFIL_OFS_FLA 6'h10
`define PFIL_OFS_FLB 6'h14
`define PFIL_OFS_DLY 6'h18
`define PFIL_OFS_BLEN 6'h1c
`define PFIL_OFS_CMP 2'h2
`define PFIL_OFS_CAPA 6'h30
`define PFIL_OFS_CAPB 6'h34
`define PFIL_OFS_STAT 6'h38

`define PFIL_CTRL_EN 0
`define PFIL_CMD_EOCUPD 0
`define PFIL_CMD_UPD 1
`define PFIL_CMD_RST 2
`define PFIL_CMD_CAPA 3
`define PFIL_CMD_CAPB 4
`define PFIL_CMD_END_OF_CYCLE_DISABLE_STROBE 5

`define PFIL_CMP_RST 12'h0ff
`define PFIL_BLEN_RST 8'h00
`define PFIL_EV_ASYNC 2'h1
`define PFIL_DSEL_BLANK 2'h1
`define PFIL_DSEL_EVOUT 2'h2

`define PFIL_M_OFF 4'h0
`define PFIL_M_1 4'h1
`define PFIL_M_2 4'h2
`define PFIL_M_3 4'h3
`define PFIL_M_4 4'h4
`define PFIL_M_5 4'h5

`define PFIL_SYNC_STAGES 2
`define PFIL_FILT_LEN 4

`endif

/* File: logic/pfil_pkg.sv */
// types shared by the pwm fault input logic
// assumes the defines header carries all numeric constants
package pfil_pkg;

  // four sequencer states of one timer cycle
  typedef enum logic [1:0] {st_dta, st_ota, st_dtb, st_otb} pfil_state_e;

  // event input configuration, one per input
  typedef struct packed {
    logic [1:0] cfg;
    logic       filter;
    logic       action;
    logic       trig_en;
  } pfil_evcfg_s;

  // delay logic configuration, double buffered
  typedef struct packed {
    logic [1:0] div;
    logic [1:0] src;
    logic [1:0] sel;
  } pfil_dlycfg_s;

endpackage

/* File: logic/pfil_top.sv */
// pwm fault input logic: event inputs, blanking, filter, sequencer, registers
// assumes an avalon-mm master on i_ref_clk and events synchronous to it
`timescale 1ns/1ps
`include "pfil_defs.svh"

module pfil_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_event_a,
  input  wire logic        i_event_b,
  input  wire logic [5:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  output logic             o_wave_out_a,
  output logic             o_wave_out_b,
  output logic             o_delay_event
);

  // state and configuration
  pfil_pkg::pfil_state_e  state_reg;
  pfil_pkg::pfil_state_e  st_next;
  pfil_pkg::pfil_evcfg_s  evc_reg [2];
  pfil_pkg::pfil_dlycfg_s dly_sh_reg;
  pfil_pkg::pfil_dlycfg_s dly_act_reg;
  logic [3:0]             fm_reg [2];
  logic [11:0]            cmp_sh_reg [4];
  logic [11:0]            cmp_act_reg [4];
  logic [11:0]            cnt_reg;
  logic [11:0]            cnt_next;
  logic [11:0]            cap_a_reg;
  logic [11:0]            cap_b_reg;
  logic [7:0]             blen_sh_reg;
  logic [7:0]             blen_act_reg;
  logic [7:0]             bcnt_reg;
  logic [2:0]             pcnt_reg;
  logic [1:0]             wait_reg;
  logic [31:0]            rd_mux;
  logic [31:0]            rdata_reg;
  logic                   en_reg;
  logic                   dis_pend_reg;
  logic                   upd_pend_reg;
  logic                   brun_reg;
  logic                   wreq_reg;
  logic                   wa_reg;
  logic                   wb_reg;
  logic                   dev_reg;

  // per-input event levels and capture edge strobes
  wire [1:0] flt_seq;
  wire [1:0] flt_ovr;
  wire [1:0] cap_ev;

  // true in dead or on time of channel a
  function automatic logic f_is_a(input pfil_pkg::pfil_state_e s);
    f_is_a = (s == pfil_pkg::st_dta) || (s == pfil_pkg::st_ota);
  endfunction

  // modes acting on the own channel only
  function automatic logic f_own(input logic [3:0] m);
    f_own = (m == `PFIL_M_1) || (m == `PFIL_M_2) || (m == `PFIL_M_3);
  endfunction

  // prescaler terminal count for divide by 1, 2, 4, 8
  function automatic logic [2:0] f_div_lim(input logic [1:0] d);
    case (d)
      2'h0:    f_div_lim = 3'h0;
      2'h1:    f_div_lim = 3'h1;
      2'h2:    f_div_lim = 3'h3;
      default: f_div_lim = 3'h7;
    endcase
  endfunction

  // bus handshake: one wait cycle, then the access completes
  wire       wr_acc  = i_write & ~wreq_reg;
  wire       wr_ctrl = wr_acc && (i_address == `PFIL_OFS_CTRL);
  wire       wr_cmd  = wr_acc && (i_address == `PFIL_OFS_CMD);
  wire       wr_cmp  = wr_acc && (i_address[5:4] == `PFIL_OFS_CMP);
  wire [1:0] cmp_idx = i_address[3:2];
  wire       wreq_next = wreq_reg ? ~(i_read | i_write) : 1'b1;

  // command strobes, acted on only while running
  wire [5:0] cmd = (wr_cmd && en_reg) ? i_writedata[5:0] : 6'h00;

  // sequencer decode
  wire [1:0]  st_idx   = state_reg;
  wire [1:0]  nxt_idx  = st_next;
  wire [11:0] cur_len  = cmp_act_reg[st_idx];
  wire        end_st   = cnt_reg == cur_len;
  wire        in_a     = f_is_a(state_reg);
  wire        jump_a   = flt_seq[0] & f_own(fm_reg[0]) & in_a;
  wire        jump_b   = flt_seq[1] & f_own(fm_reg[1]) & ~in_a;
  wire        m3a      = flt_seq[0] & (fm_reg[0] == `PFIL_M_3);
  wire        m3b      = flt_seq[1] & (fm_reg[1] == `PFIL_M_3);
  wire [1:0]  is5      = {fm_reg[1] == `PFIL_M_5, fm_reg[0] == `PFIL_M_5};
  wire [1:0]  is45     = is5 | {fm_reg[1] == `PFIL_M_4, fm_reg[0] == `PFIL_M_4};
  wire        any5     = |(flt_seq & is5);
  wire        off_all  = |(flt_ovr & is45);
  wire        hold1a   = wait_reg[0] & flt_seq[0] & (fm_reg[0] == `PFIL_M_1)
                         & (state_reg == pfil_pkg::st_dtb) & (cnt_reg == 12'h000);
  wire        hold1b   = wait_reg[1] & flt_seq[1] & (fm_reg[1] == `PFIL_M_1)
                         & (state_reg == pfil_pkg::st_dta) & (cnt_reg == 12'h000);
  wire        hold2a   = wait_reg[0] & flt_seq[0] & (fm_reg[0] == `PFIL_M_2)
                         & (state_reg == pfil_pkg::st_otb) & end_st;
  wire        hold2b   = wait_reg[1] & flt_seq[1] & (fm_reg[1] == `PFIL_M_2)
                         & (state_reg == pfil_pkg::st_ota) & end_st;
  wire        hold     = hold1a | hold1b | hold2a | hold2b;
  wire        cyc_end  = en_reg & (state_reg == pfil_pkg::st_otb)
                         & (st_next == pfil_pkg::st_dta);
  wire        load     = cmd[`PFIL_CMD_UPD] | (upd_pend_reg & cyc_end)
                         | (wr_ctrl & i_writedata[`PFIL_CTRL_EN] & ~en_reg);

  // delay logic decode, shared by blanking and output event
  wire       ptick     = pcnt_reg == f_div_lim(dly_act_reg.div);
  wire [7:0] bcnt_inc  = bcnt_reg + 8'h01;
  wire       bdone     = brun_reg & ptick & (bcnt_inc == blen_act_reg);
  wire       blank_act = brun_reg & (dly_act_reg.sel == `PFIL_DSEL_BLANK);
  wire       dtrig     = en_reg & (dly_act_reg.sel != 2'h0) & (st_next != state_reg)
                         & (nxt_idx == dly_act_reg.src);

  // outputs next: on time of own channel unless overridden
  wire wa_next = en_reg & (state_reg == pfil_pkg::st_ota) & ~off_all
                 & ~(flt_ovr[0] & f_own(fm_reg[0]));
  wire wb_next = en_reg & (state_reg == pfil_pkg::st_otb) & ~off_all
                 & ~(flt_ovr[1] & f_own(fm_reg[1]));

  // input conditioning, identical for both inputs except that blanking masks input a only
  genvar gi;
  for (gi = 0; gi < 2; gi++) begin : g_in
    logic       s1_reg;
    logic       s2_reg;
    logic       fl_reg;
    logic       pq_reg;
    logic [2:0] fs_reg;
    wire        raw  = (gi == 0) ? i_event_a : i_event_b;
    wire        proc = evc_reg[gi].filter ? fl_reg : s2_reg;
    wire        ovr  = (evc_reg[gi].cfg == `PFIL_EV_ASYNC) ? raw : proc;
    wire        mask = (gi == 0) & blank_act;
    wire        fen  = evc_reg[gi].trig_en & ~evc_reg[gi].action
                       & (fm_reg[gi] != `PFIL_M_OFF) & ~mask;

    // two-stage synchroniser, then four-sample agreement filter
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        fs_reg <= 3'h0;
        fl_reg <= 1'b0;
        pq_reg <= 1'b0;
      end else begin
        s1_reg <= raw;
        s2_reg <= s1_reg;
        fs_reg <= {fs_reg[1:0], s2_reg};
        if (&{fs_reg, s2_reg}) fl_reg <= 1'b1;
        else if (~|{fs_reg, s2_reg}) fl_reg <= 1'b0;
        pq_reg <= proc;
      end
    end

    assign flt_seq[gi] = fen & proc;
    assign flt_ovr[gi] = fen & ovr;
    assign cap_ev[gi]  = evc_reg[gi].trig_en & evc_reg[gi].action
                         & proc & ~pq_reg & ~mask;
  end

  // compare shadows and active copies
  genvar ci;
  for (ci = 0; ci < 4; ci++) begin : g_cmp
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        cmp_sh_reg[ci]  <= `PFIL_CMP_RST;
        cmp_act_reg[ci] <= `PFIL_CMP_RST;
      end else begin
        if (wr_cmp && (cmp_idx == ci)) cmp_sh_reg[ci] <= i_writedata[11:0];
        if (load) cmp_act_reg[ci] <= cmp_sh_reg[ci];
      end
    end
  end

  // sequencer next state, fault jumps before holds before normal steps
  always_comb begin
    st_next  = state_reg;
    cnt_next = cnt_reg + 12'h001;
    if (!en_reg || cmd[`PFIL_CMD_RST]) begin
      st_next  = pfil_pkg::st_dta;
      cnt_next = 12'h000;
    end else if (jump_a) begin
      st_next  = pfil_pkg::st_dtb;
      cnt_next = 12'h000;
    end else if (jump_b) begin
      st_next  = pfil_pkg::st_dta;
      cnt_next = 12'h000;
    end else if (any5 && state_reg == pfil_pkg::st_ota) begin
      st_next  = pfil_pkg::st_dtb;
      cnt_next = 12'h000;
    end else if (any5 && state_reg == pfil_pkg::st_otb) begin
      st_next  = pfil_pkg::st_dta;
      cnt_next = 12'h000;
    end else if (hold) begin
      cnt_next = cnt_reg;
    end else if (end_st) begin
      cnt_next = 12'h000;
      case (state_reg)
        pfil_pkg::st_dta: st_next = any5 ? pfil_pkg::st_dtb : pfil_pkg::st_ota;
        pfil_pkg::st_ota: st_next = m3b ? pfil_pkg::st_dta : pfil_pkg::st_dtb;
        pfil_pkg::st_dtb: st_next = any5 ? pfil_pkg::st_dta : pfil_pkg::st_otb;
        default:          st_next = m3a ? pfil_pkg::st_dtb : pfil_pkg::st_dta;
      endcase
    end
  end

  // sequencer state, wait flags, captures and outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_reg <= pfil_pkg::st_dta;
      cnt_reg   <= 12'h000;
      wait_reg  <= 2'h0;
      cap_a_reg <= 12'h000;
      cap_b_reg <= 12'h000;
      wa_reg    <= 1'b0;
      wb_reg    <= 1'b0;
    end else begin
      state_reg <= st_next;
      cnt_reg   <= cnt_next;
      if (jump_a) wait_reg[0] <= 1'b1;
      else if (st_next == pfil_pkg::st_dta) wait_reg[0] <= 1'b0;
      if (jump_b) wait_reg[1] <= 1'b1;
      else if (st_next == pfil_pkg::st_dtb) wait_reg[1] <= 1'b0;
      if (cap_ev[0] || cmd[`PFIL_CMD_CAPA]) cap_a_reg <= cnt_reg;
      if (cap_ev[1] || cmd[`PFIL_CMD_CAPB]) cap_b_reg <= cnt_reg;
      wa_reg <= wa_next;
      wb_reg <= wb_next;
    end
  end

  // software registers: enable, pending strobes, static and buffered config
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      en_reg       <= 1'b0;
      dis_pend_reg <= 1'b0;
      upd_pend_reg <= 1'b0;
      evc_reg[0]   <= '0;
      evc_reg[1]   <= '0;
      fm_reg[0]    <= `PFIL_M_OFF;
      fm_reg[1]    <= `PFIL_M_OFF;
      dly_sh_reg   <= '0;
      dly_act_reg  <= '0;
      blen_sh_reg  <= `PFIL_BLEN_RST;
      blen_act_reg <= `PFIL_BLEN_RST;
    end else begin
      if (wr_ctrl) en_reg <= i_writedata[`PFIL_CTRL_EN];
      else if (dis_pend_reg && cyc_end) en_reg <= 1'b0;
      if (cmd[`PFIL_CMD_END_OF_CYCLE_DISABLE_STROBE]) dis_pend_reg <= 1'b1;
      else if (cyc_end || !en_reg) dis_pend_reg <= 1'b0;
      if (cmd[`PFIL_CMD_EOCUPD]) upd_pend_reg <= 1'b1;
      else if (cyc_end || !en_reg) upd_pend_reg <= 1'b0;
      if (!en_reg && wr_acc) begin
        if (i_address == `PFIL_OFS_EVA) evc_reg[0] <= i_writedata[4:0];
        if (i_address == `PFIL_OFS_EVB) evc_reg[1] <= i_writedata[4:0];
        if (i_address == `PFIL_OFS_FLA) fm_reg[0] <= i_writedata[3:0];
        if (i_address == `PFIL_OFS_FLB) fm_reg[1] <= i_writedata[3:0];
      end
      if (wr_acc && i_address == `PFIL_OFS_DLY) dly_sh_reg <= i_writedata[5:0];
      if (wr_acc && i_address == `PFIL_OFS_BLEN) blen_sh_reg <= i_writedata[7:0];
      if (load) begin
        dly_act_reg  <= dly_sh_reg;
        blen_act_reg <= blen_sh_reg;
      end
    end
  end

  // delay counter: prescaled count up to the blanking length
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      brun_reg <= 1'b0;
      bcnt_reg <= 8'h00;
      pcnt_reg <= 3'h0;
      dev_reg  <= 1'b0;
    end else begin
      dev_reg <= bdone & (dly_act_reg.sel == `PFIL_DSEL_EVOUT);
      if (!en_reg) begin
        brun_reg <= 1'b0;
      end else if (dtrig) begin
        brun_reg <= blen_act_reg != 8'h00;
        bcnt_reg <= 8'h00;
        pcnt_reg <= 3'h0;
      end else if (brun_reg) begin
        if (ptick) begin
          pcnt_reg <= 3'h0;
          bcnt_reg <= bcnt_inc;
          if (bdone) brun_reg <= 1'b0;
        end else begin
          pcnt_reg <= pcnt_reg + 3'h1;
        end
      end
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (i_address == `PFIL_OFS_CTRL) rd_mux = {31'h0, en_reg};
    else if (i_address == `PFIL_OFS_EVA) rd_mux = {27'h0, evc_reg[0]};
    else if (i_address == `PFIL_OFS_EVB) rd_mux = {27'h0, evc_reg[1]};
    else if (i_address == `PFIL_OFS_FLA) rd_mux = {28'h0, fm_reg[0]};
    else if (i_address == `PFIL_OFS_FLB) rd_mux = {28'h0, fm_reg[1]};
    else if (i_address == `PFIL_OFS_DLY) rd_mux = {26'h0, dly_sh_reg};
    else if (i_address == `PFIL_OFS_BLEN) rd_mux = {24'h0, blen_sh_reg};
    else if (i_address[5:4] == `PFIL_OFS_CMP) rd_mux = {20'h0, cmp_sh_reg[cmp_idx]};
    else if (i_address == `PFIL_OFS_CAPA) rd_mux = {20'h0, cap_a_reg};
    else if (i_address == `PFIL_OFS_CAPB) rd_mux = {20'h0, cap_b_reg};
    else if (i_address == `PFIL_OFS_STAT)
      rd_mux = {24'h0, dis_pend_reg, upd_pend_reg, flt_seq, blank_act, st_idx, en_reg};
  end

  // bus slave flops
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wreq_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wreq_reg <= wreq_next;
      if (i_read && wreq_reg) rdata_reg <= rd_mux;
    end
  end

  assign o_readdata    = rdata_reg;
  assign o_waitrequest = wreq_reg;
  assign o_wave_out_a  = wa_reg;
  assign o_wave_out_b  = wb_reg;
  assign o_delay_event = dev_reg;

  // checks
  property p_dis_now;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    wr_ctrl && !i_writedata[`PFIL_CTRL_EN] |=> !en_reg ##1 !o_wave_out_a && !o_wave_out_b;
  endproperty
  a_dis_now: assert property (p_dis_now) else $error("enable clear did not stop");

  property p_dis_eoc;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    dis_pend_reg && cyc_end && !wr_ctrl |=> !en_reg && state_reg == pfil_pkg::st_dta;
  endproperty
  a_dis_eoc: assert property (p_dis_eoc) else $error("cycle end disable missed");

  property p_trig_off;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    !evc_reg[1].trig_en |-> !flt_seq[1] && !cap_ev[1];
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("disabled input acted");

  property p_mode_off;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    en_reg && state_reg == pfil_pkg::st_ota && fm_reg[0] == `PFIL_M_OFF
      && fm_reg[1] == `PFIL_M_OFF |=> o_wave_out_a;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode zero touched output");

  property p_filter;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(g_in[0].fl_reg) |-> $past(g_in[0].s2_reg, 1) && $past(g_in[0].s2_reg, 2)
      && $past(g_in[0].s2_reg, 3) && $past(g_in[0].s2_reg, 4);
  endproperty
  a_filter: assert property (p_filter) else $error("short pulse passed filter");

  property p_mode1_jump;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    en_reg && !wr_ctrl && !cmd[`PFIL_CMD_RST] && jump_a
      |=> state_reg == pfil_pkg::st_dtb && cnt_reg == 12'h000 ##1 !o_wave_out_a;
  endproperty
  a_mode1_jump: assert property (p_mode1_jump) else $error("own fault no jump");

  property p_hold;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    en_reg && !wr_ctrl && !cmd[`PFIL_CMD_RST] && hold && !any5 && !jump_a && !jump_b
      |=> $stable(cnt_reg) && $stable(state_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved during wait");

  property p_mode5;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    en_reg && !wr_ctrl && !cmd[`PFIL_CMD_RST] && any5 && state_reg == pfil_pkg::st_ota
      |=> state_reg == pfil_pkg::st_dtb ##1 !o_wave_out_a && !o_wave_out_b;
  endproperty
  a_mode5: assert property (p_mode5) else $error("mode five no dead time");

  property p_order;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    en_reg && !wr_ctrl && !cmd[`PFIL_CMD_RST] && flt_seq == 2'h0 && end_st
      && state_reg == pfil_pkg::st_dtb |=> state_reg == pfil_pkg::st_otb;
  endproperty
  a_order: assert property (p_order) else $error("state order broken");

  property p_blank;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    blank_act |-> !flt_seq[0] && !flt_ovr[0] && !cap_ev[0];
  endproperty
  a_blank: assert property (p_blank) else $error("blanked event used");

endmodule

/* File: testbench/pfil_event_src.sv */
// event source standing in for the on-chip event routing fabric
// assumes the bench asks for levels just after a rising edge of i_ref_clk
`timescale 1ns/1ps

module pfil_event_src (
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_level_a,
  input  wire logic i_level_b,
  output logic      o_event_a,
  output logic      o_event_b
);
  // levels leave on a clock edge and stay as long as asked, low in reset
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_event_a <= 1'b0;
      o_event_b <= 1'b0;
    end else begin
      o_event_a <= i_level_a;
      o_event_b <= i_level_b;
    end
  end
endmodule

/* File: testbench/pfil_top_tb_top.sv */
// bench for the pwm fault input logic: avalon tasks, fault cases, disables
// assumes one 20 MHz clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "pfil_defs.svh"

module pfil_top_tb_top;
  logic        i_ref_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        lvl_a = 1'b0;
  logic        lvl_b = 1'b0;
  logic        ev_a;
  logic        ev_b;
  logic [5:0]  i_address = 6'h00;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic        o_wave_out_a;
  logic        o_wave_out_b;
  logic        o_delay_event;
  logic [31:0] rd;
  logic [7:0]  n_ev;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #25 i_ref_clk = ~i_ref_clk;

  pfil_event_src pfil_event_src_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_level_a(lvl_a), .i_level_b(lvl_b), .o_event_a(ev_a), .o_event_b(ev_b));

  pfil_top pfil_top_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_event_a(ev_a),
    .i_event_b(ev_b), .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_wave_out_a(o_wave_out_a), .o_wave_out_b(o_wave_out_b),
    .o_delay_event(o_delay_event));

  // verdict and end of run
  task results();
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      results();
    end
  end

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task bus(input logic we, input logic [5:0] adr, input logic [31:0] wd);
    @(posedge i_ref_clk);
    i_write <= we;
    i_read <= ~we;
    i_address <= adr;
    i_writedata <= wd;
    do @(posedge i_ref_clk); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task wr(input logic [5:0] adr, input logic [31:0] wd);
    bus(1'b1, adr, wd);
  endtask

  task rd_chk(input string name, input logic [5:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(name, exp, rd);
  endtask

  // high cycles of each output over two 16-cycle timer periods
  task count_hi(output logic [7:0] ca, output logic [7:0] cb);
    ca = 8'h00;
    cb = 8'h00;
    repeat (32) begin
      @(posedge i_ref_clk);
      ca = ca + {7'h0, o_wave_out_a === 1'b1};
      cb = cb + {7'h0, o_wave_out_b === 1'b1};
    end
  endtask

  // reconfigure while disabled, drive events, enable, measure outputs
  task run_case(input logic [7:0] eva, fla, evb, flb, dly, bl,
                input logic ea, eb, input logic [7:0] xa, xb);
    logic [7:0] ca;
    logic [7:0] cb;
    wr(`PFIL_OFS_CTRL, 32'h0);
    wr(`PFIL_OFS_EVA, {24'h0, eva});
    wr(`PFIL_OFS_FLA, {24'h0, fla});
    wr(`PFIL_OFS_EVB, {24'h0, evb});
    wr(`PFIL_OFS_FLB, {24'h0, flb});
    wr(`PFIL_OFS_DLY, {24'h0, dly});
    wr(`PFIL_OFS_BLEN, {24'h0, bl});
    lvl_a <= ea;
    lvl_b <= eb;
    wr(`PFIL_OFS_CTRL, 32'h1);
    repeat (48) @(posedge i_ref_clk);
    count_hi(ca, cb);
    check("wave_a_high", {24'h0, xa}, {24'h0, ca});
    check("wave_b_high", {24'h0, xb}, {24'h0, cb});
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    rd_chk("cmp_rst", 6'h20, {20'h0, `PFIL_CMP_RST});
    rd_chk("blen_rst", `PFIL_OFS_BLEN, 32'h0);
    rd_chk("ctrl_rst", `PFIL_OFS_CTRL, 32'h0);
    rd_chk("unmapped", 6'h3c, 32'h0);
    for (int k = 0; k < 4; k++) wr(6'h20 + 6'(4 * k), 32'h3);
    run_case(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'h08, 8'h08);
    run_case(8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'h08, 8'h08);
    run_case(8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'h08, 8'h08);
    run_case(8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'h00, 8'h00);
    run_case(8'h00, 8'h00, 8'h01, 8'h04, 8'h00, 8'h00, 0, 1, 8'h00, 8'h00);
    run_case(8'h09, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'h00, 8'h00);
    run_case(8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'h00, 8'h00);
    run_case(8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'h00, 8'h00);
    run_case(8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'h00, 8'h20);
    run_case(8'h00, 8'h00, 8'h01, 8'h03, 8'h00, 8'h00, 0, 1, 8'h10, 8'h00);
    run_case(8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 1, 0, 8'h00, 8'h00);
    run_case(8'h01, 8'h04, 8'h00, 8'h00, 8'h09, 8'h08, 1, 0, 8'h00, 8'h08);
    run_case(8'h01, 8'h04, 8'h00, 8'h00, 8'h19, 8'h04, 1, 0, 8'h00, 8'h08);
    run_case(8'h00, 8'h00, 8'h01, 8'h04, 8'h09, 8'h08, 0, 1, 8'h00, 8'h00);
    // output event on every dead a entry: one pulse per 16-cycle period
    run_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 0, 0, 8'h08, 8'h08);
    n_ev = 8'h00;
    repeat (32) begin
      @(posedge i_ref_clk);
      n_ev = n_ev + {7'h0, o_delay_event === 1'b1};
    end
    check("delay_event_pulses", 32'h2, {24'h0, n_ev});
    run_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 0, 0, 8'h08, 8'h08);
    // restart lands in dead a; soft capture six cycles later takes count 1 in on time a
    wr(`PFIL_OFS_CMD, 32'h04);
    bus(1'b0, `PFIL_OFS_STAT, 32'h0);
    check("restart_state", 32'h1, rd & 32'h7);
    wr(`PFIL_OFS_CMD, 32'h08);
    rd_chk("soft_capture_a", `PFIL_OFS_CAPA, 32'h1);
    wr(`PFIL_OFS_EVA, 32'h1f);
    rd_chk("eva_locked", `PFIL_OFS_EVA, 32'h0);
    while (o_wave_out_a !== 1'b1) @(posedge i_ref_clk);
    wr(`PFIL_OFS_CMD, 32'h20);
    bus(1'b0, `PFIL_OFS_STAT, 32'h0);
    check("still_pending", 32'h81, rd & 32'h81);
    check("still_on_bit", 32'h1, rd & 32'h1);
    repeat (20) @(posedge i_ref_clk);
    bus(1'b0, `PFIL_OFS_STAT, 32'h0);
    check("eoc_off", 32'h0, rd & 32'h1);
    wr(`PFIL_OFS_CTRL, 32'h1);
    repeat (10) @(posedge i_ref_clk);
    wr(`PFIL_OFS_CTRL, 32'h0);
    rd_chk("ctrl_off", `PFIL_OFS_CTRL, 32'h0);
    bus(1'b0, `PFIL_OFS_STAT, 32'h0);
    check("stat_off", 32'h0, rd & 32'h1);
    results();
  end
endmodule
